// file: sbd_pkg.sv
package sbd_pkg;
  // ---------------------------------------------------------------
  // filter geometry
  // ---------------------------------------------------------------
  localparam int SBD_ACC_W = 24;
  localparam int SBD_WORD_W = 16;
  localparam int SBD_CNT_W = 8;
  localparam int SBD_WORD_LSB = 8;
  localparam logic [23:0] SBD_ACC_RST = 24'h00_0000;
  localparam logic [7:0] SBD_CNT_RST = 8'h00;
  localparam logic [15:0] SBD_WORD_RST = 16'h0000;
  // ---------------------------------------------------------------
  // modulator timing and densities
  // ---------------------------------------------------------------
  localparam int SBD_CLK_MHZ = 40;
  localparam int SBD_MOD_MHZ = 10;
  localparam int SBD_MOD_DIV = SBD_CLK_MHZ / SBD_MOD_MHZ;
  localparam int SBD_MOD_HALF = SBD_MOD_DIV / 2;
  localparam logic [7:0] SBD_DIV_RST = 8'h00;
  // density in sixteenths: 13/16 = 81.25 %, 3/16 = 18.75 %
  localparam logic [4:0] SBD_DEN_ZERO = 5'h08;
  localparam logic [4:0] SBD_DEN_POS = 5'h0d;
  localparam logic [4:0] SBD_DEN_NEG = 5'h03;
  localparam logic [4:0] SBD_DEN_FULL = 5'h10;
  localparam logic [4:0] SBD_DEN_STEPS = 5'h10;
  localparam logic [4:0] SBD_DEN_RST = 5'h00;
  typedef enum logic [1:0] {
    SBD_IN_ZERO = 2'b00,
    SBD_IN_POS = 2'b01,
    SBD_IN_FULL = 2'b11,
    SBD_IN_NEG = 2'b10
  } sbd_level_t;
endpackage

// file: sbd_link_if.sv
`timescale 1ns/1ps
interface sbd_link_if;
  logic modulator_clock_in;
  logic modulator_bitstream_out;
  modport modulator (
    input modulator_clock_in,
    output modulator_bitstream_out
  );
  modport filter (
    output modulator_clock_in,
    input modulator_bitstream_out
  );
endinterface

// file: sbd_modulator.sv
`timescale 1ns/1ps
module sbd_modulator
  import sbd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  sbd_link_if.modulator link,
  input wire sbd_level_t input_level
);
  // ---------------------------------------------------------------
  // bit clock edge detect, clock is sampled synchronously
  // ---------------------------------------------------------------
  logic mclk_reg;
  logic bit_reg;
  logic [4:0] err_reg;
  wire rise = link.modulator_clock_in & ~mclk_reg;
  // ---------------------------------------------------------------
  // first-order density generator over sixteen bit periods
  // ---------------------------------------------------------------
  logic [4:0] dens;
  always_comb begin
    case (input_level)
      SBD_IN_POS: dens = SBD_DEN_POS;
      SBD_IN_NEG: dens = SBD_DEN_NEG;
      SBD_IN_FULL: dens = SBD_DEN_FULL;
      default: dens = SBD_DEN_ZERO;
    endcase
  end
  wire [5:0] sum = {1'b0, err_reg} + {1'b0, dens};
  wire hit = sum >= {1'b0, SBD_DEN_STEPS};
  wire [5:0] wrap = hit ? sum - {1'b0, SBD_DEN_STEPS} : sum;
  wire [4:0] err_wrap = wrap[4:0];
  wire bit_next = rise ? hit : bit_reg;
  wire [4:0] err_next = rise ? err_wrap : err_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      mclk_reg <= 1'b0;
      bit_reg <= 1'b0;
      err_reg <= SBD_DEN_RST;
    end else begin
      mclk_reg <= link.modulator_clock_in;
      bit_reg <= bit_next;
      err_reg <= err_next;
    end
  end
  assign link.modulator_bitstream_out = bit_reg;
endmodule

// file: sbd_filter.sv
`timescale 1ns/1ps
module sbd_filter
  import sbd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  sbd_link_if.filter link,
  output logic word_valid,
  input wire logic word_ready,
  output logic [15:0] word_data
);
  // ---------------------------------------------------------------
  // modulator clock divider
  // ---------------------------------------------------------------
  logic [7:0] div_reg;
  logic mclk_reg;
  wire div_end = div_reg == 8'(SBD_MOD_DIV - 1);
  wire [7:0] div_next = div_end ? SBD_DIV_RST : div_reg + 8'h01;
  wire mclk_next = div_reg < 8'(SBD_MOD_HALF);
  wire fall = mclk_reg & ~mclk_next;
  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= SBD_DIV_RST;
      mclk_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      mclk_reg <= mclk_next;
    end
  end
  assign link.modulator_clock_in = mclk_reg;
  // ---------------------------------------------------------------
  // bit input
  // ---------------------------------------------------------------
  logic filter_bit_in;
  assign filter_bit_in = link.modulator_bitstream_out;
  wire [23:0] bit_val = {23'h00_0000, filter_bit_in};

  // ---------------------------------------------------------------
  // word counter and stall control
  // ---------------------------------------------------------------
  logic [7:0] cnt_reg;
  logic [1:0] fill_reg;
  wire [7:0] cnt_inc = cnt_reg + 8'h01;
  wire word_due = fall & ~cnt_reg[7] & cnt_inc[7];
  wire buf_full = fill_reg == 2'd2;
  wire stall = word_due & buf_full;
  wire step = fall & ~stall;
  wire word_tick = word_due & step;
  wire [7:0] cnt_next = step ? cnt_inc : cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= SBD_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // integrators at bit rate
  // ---------------------------------------------------------------
  logic [23:0] integrator_stage_one;
  logic [23:0] int2_reg;
  logic [23:0] int3_reg;
  wire [23:0] int1_sum = integrator_stage_one + bit_val;
  wire [23:0] int2_sum = int2_reg + integrator_stage_one;
  wire [23:0] int3_sum = int3_reg + int2_reg;
  wire [23:0] int1_next = step ? int1_sum : integrator_stage_one;
  wire [23:0] int2_next = step ? int2_sum : int2_reg;
  wire [23:0] int3_next = step ? int3_sum : int3_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      integrator_stage_one <= SBD_ACC_RST;
    end else begin
      integrator_stage_one <= int1_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int2_reg <= SBD_ACC_RST;
    end else begin
      int2_reg <= int2_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int3_reg <= SBD_ACC_RST;
    end else begin
      int3_reg <= int3_next;
    end
  end

  // ---------------------------------------------------------------
  // differentiators at word rate
  // ---------------------------------------------------------------
  logic [23:0] int3_d_reg;
  logic [23:0] diff1_reg;
  logic [23:0] diff2_reg;
  logic [23:0] final_difference;
  logic [23:0] diff1_d_reg;
  logic [23:0] diff2_d_reg;
  logic word_pend_reg;
  wire [23:0] diff1_sub = int3_reg - int3_d_reg;
  wire [23:0] diff2_sub = diff1_reg - diff1_d_reg;
  wire [23:0] final_difference_sub = diff2_reg - diff2_d_reg;
  wire [23:0] diff1_next = word_tick ? diff1_sub : diff1_reg;
  wire [23:0] diff2_next = word_tick ? diff2_sub : diff2_reg;
  wire [23:0] final_difference_next = word_tick ? final_difference_sub : final_difference;
  wire [23:0] int3_d_next = word_tick ? int3_reg : int3_d_reg;
  wire [23:0] diff1_d_next = word_tick ? diff1_reg : diff1_d_reg;
  wire [23:0] diff2_d_next = word_tick ? diff2_reg : diff2_d_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      diff1_reg <= SBD_ACC_RST;
      int3_d_reg <= SBD_ACC_RST;
    end else begin
      diff1_reg <= diff1_next;
      int3_d_reg <= int3_d_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      diff2_reg <= SBD_ACC_RST;
      diff1_d_reg <= SBD_ACC_RST;
    end else begin
      diff2_reg <= diff2_next;
      diff1_d_reg <= diff1_d_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      final_difference <= SBD_ACC_RST;
      diff2_d_reg <= SBD_ACC_RST;
    end else begin
      final_difference <= final_difference_next;
      diff2_d_reg <= diff2_d_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      word_pend_reg <= 1'b0;
    end else begin
      word_pend_reg <= word_tick;
    end
  end

  wire [15:0] word_in = final_difference[SBD_ACC_W-1:SBD_WORD_LSB];

  // ---------------------------------------------------------------
  // output buffer selection
  // ---------------------------------------------------------------
  logic [15:0] buf0_reg;
  logic [15:0] buf1_reg;
  wire push = word_pend_reg;
  wire pop = word_valid & word_ready;
  wire fill_zero = fill_reg == 2'd0;
  wire [1:0] fill_next = fill_reg + {1'b0, push} - {1'b0, pop};
  wire valid_next = fill_next != 2'd0;
  wire [15:0] head_after_pop = buf_full ? buf1_reg : word_in;
  wire load_head = push & fill_zero;
  wire [15:0] buf0_next = pop ? head_after_pop : load_head ? word_in : buf0_reg;
  wire [15:0] buf1_next = (pop | (push & ~fill_zero)) ? word_in : buf1_reg;
  wire [15:0] data_next = pop ? head_after_pop : load_head ? word_in : buf0_reg;

  // ---------------------------------------------------------------
  // output buffer state
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fill_reg <= 2'd0;
      word_valid <= 1'b0;
    end else begin
      fill_reg <= fill_next;
      word_valid <= valid_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf0_reg <= SBD_WORD_RST;
      buf1_reg <= SBD_WORD_RST;
    end else begin
      buf0_reg <= buf0_next;
      buf1_reg <= buf1_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      word_data <= SBD_WORD_RST;
    end else begin
      word_data <= data_next;
    end
  end
endmodule

// file: sbd_link_props.sv
`timescale 1ns/1ps
module sbd_link_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic modulator_clock_in,
  input wire logic modulator_bitstream_out
);
  // ----------------------------------
  // link timing checks
  // ----------------------------------
  wire mc = modulator_clock_in;
  wire bo = modulator_bitstream_out;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_CLK_HIGH: assert property ($rose(mc) |-> mc[*2] ##1 !mc)
    else $error("clock high time");
  AST_CLK_LOW: assert property ($fell(mc) |-> !mc[*2] ##1 mc)
    else $error("clock low time");
  AST_CLK_PERIOD: assert property ($rose(mc) |-> ##4 $rose(mc))
    else $error("clock period");
  AST_CLK_MAX_HIGH: assert property (mc[*2] |=> !mc)
    else $error("clock high too long");
  AST_BIT_CHG: assert property ($changed(bo) |-> mc)
    else $error("bit moved off the high phase");
  AST_BIT_HOLD: assert property ($changed(bo) |=> $stable(bo)[*3])
    else $error("bit too short");
  AST_FALL_STABLE: assert property ($fell(mc) |-> $stable(bo))
    else $error("bit moved at sampling edge");
  AST_RST_IDLE: assert property ($fell(rst) |-> !mc && !bo)
    else $error("link not idle after reset");
endmodule

// file: tb_sinc3_bitstream_decimator.sv
`timescale 1ns/1ps
module tb_sinc3_bitstream_decimator;
  import sbd_pkg::*;
  // ----------------------------------
  // stimulus and checks
  // ----------------------------------
  logic clk = 0, rst = 1, word_ready = 0, word_valid;
  logic [15:0] word_data, cyc = 16'h0000;
  logic [7:0] lfsr = 8'h1c;
  logic [1:0] mode = 2'h0;
  sbd_level_t lvl = SBD_IN_ZERO;
  int n_errors = 0, tests_run = 0;
  sbd_link_if link ();
  sbd_modulator u_sbd_modulator (.clk(clk), .rst(rst), .link(link), .input_level(lvl));
  sbd_filter u_sbd_filter (.clk(clk), .rst(rst), .link(link), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data));
  sbd_link_props u_sbd_link_props (.clk(clk), .rst(rst), .modulator_clock_in(link.modulator_clock_in),
    .modulator_bitstream_out(link.modulator_bitstream_out));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    cyc <= cyc + 16'h0001;
    word_ready <= mode == 2'h2 || (mode == 2'h0 && lfsr[1]);
  end
  function automatic logic [15:0] dens(input sbd_level_t l);
    return 16'(l == SBD_IN_POS ? SBD_DEN_POS : l == SBD_IN_NEG ? SBD_DEN_NEG :
      l == SBD_IN_FULL ? SBD_DEN_FULL : SBD_DEN_ZERO);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic getw(output logic [15:0] w);
    int i;
    i = 0;
    do @(posedge clk); while (!(word_valid === 1'b1 && word_ready === 1'b1) && ++i < 4000);
    if (i >= 4000) n_errors++;
    w = word_data;
  endtask
  task automatic ones(output logic [15:0] c);
    c = 0;
    repeat (256) begin
      @(negedge link.modulator_clock_in);
      c += 16'(link.modulator_bitstream_out);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(80000 * 25);
    n_errors++;
    wrap_up();
  end
  initial begin
    logic [15:0] w, c;
    repeat (4) @(posedge clk);
    rst <= 0;
    for (int k = 0; k < 6; k++) begin
      lvl <= k < 4 ? sbd_level_t'(k[1:0]) : sbd_level_t'(lfsr[1:0]);
      repeat (4) getw(w);
      ones(c);
      chk(c, dens(lvl) * 16'h0010);
      repeat (2) getw(w);
      chk(w, dens(lvl) * 16'h1000);
    end
    mode <= 2'h1;
    repeat (3000) @(posedge clk);
    w = word_data;
    repeat (1100) @(posedge clk);
    chk({15'h0000, word_valid}, 16'h0001);
    chk(word_data, w);
    mode <= 2'h2;
    repeat (4) getw(w);
    c = cyc;
    getw(w);
    chk(cyc - c, 16'h0400);
    @(posedge clk);
    chk({15'h0000, word_valid}, 16'h0000);
    rst <= 1;
    repeat (2) @(posedge clk);
    chk(word_data, 16'h0000);
    chk({15'h0000, word_valid}, 16'h0000);
    rst <= 0;
    repeat (6) getw(w);
    chk(w, dens(lvl) * 16'h1000);
    wrap_up();
  end
endmodule
